/* rtl/nofp_pkg.sv */
/*
  Shared constants for the navigation output field packer: register offsets,
  field word layout, estimator status bit positions and the sequencer states.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package nofp_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_GPS_SEL = 12'h004;
  localparam logic [11:0] OFS_ATT_SEL = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [3:0] FIELD_PAGE = 4'h1;

  localparam int CTRL_GPS_EN = 0;
  localparam int CTRL_ATT_SEND = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_TRACK = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_WORD_LO = 16;

  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [15:0] GPS_SEL_USED = 16'h0F80;
  localparam logic [15:0] ATT_SEL_USED = 16'h01FF;
  localparam int ATT_BIT_STATUS = 0;

  // ----------------------------------------------------------------------
  // Field word layout
  // ----------------------------------------------------------------------
  localparam int FIELD_WORDS = 42;
  localparam logic [5:0] GPS_FIRST = 6'h00;
  localparam logic [5:0] GPS_LAST = 6'h0A;
  localparam logic [5:0] ATT_FIRST = 6'h0B;
  localparam logic [5:0] ATT_LAST = 6'h29;
  localparam logic [2:0] WORD_BYTES = 3'h4;
  localparam logic [2:0] STATUS_BYTES = 3'h2;

  // ----------------------------------------------------------------------
  // Estimator status word bit positions
  // ----------------------------------------------------------------------
  localparam int ST_QUALITY = 0;
  localparam int ST_RATE_CLIP = 2;
  localparam int ST_RATE_REC = 3;
  localparam int ST_MAG_INT = 4;
  localparam int ST_MAG_CLIP = 6;
  localparam int ST_ACC_INT = 7;
  localparam int ST_ACC_CLIP = 9;
  localparam int ST_INTERNAL = 10;
  localparam int ST_DECL_MAG = 11;
  localparam int ST_DECL_ACC = 12;

  typedef enum logic [1:0] {
    NOFP_IDLE = 2'b00,
    NOFP_STATUS = 2'b01,
    NOFP_WORDS = 2'b10
  } nofp_state_t;

  // Selection mask bit that owns a given field word.
  function automatic logic [3:0] nofp_word_field(input logic [5:0] idx);
    logic [3:0] f;
    f = 4'h0;
    if (idx < 6'h03) f = 4'h7;
    else if (idx < 6'h06) f = 4'h8;
    else if (idx < 6'h09) f = 4'h9;
    else if (idx < 6'h0A) f = 4'hA;
    else if (idx < 6'h0B) f = 4'hB;
    else if (idx < 6'h0E) f = 4'h1;
    else if (idx < 6'h12) f = 4'h2;
    else if (idx < 6'h1B) f = 4'h3;
    else if (idx < 6'h1E) f = 4'h4;
    else if (idx < 6'h21) f = 4'h5;
    else if (idx < 6'h24) f = 4'h6;
    else if (idx < 6'h27) f = 4'h7;
    else f = 4'h8;
    return f;
  endfunction

endpackage

/* rtl/nofp_byte_serializer.sv */
/*
  Turns one loaded word into a stream of bytes, least significant first,
  with valid/ready handshake and a last-byte marker.
  Assumes load is only honoured while the serializer is idle.
*/
`timescale 1ns/1ps
`default_nettype none

module nofp_byte_serializer #(
  parameter int WORD_W = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic load,
  input wire logic [WORD_W-1:0] word,
  input wire logic [2:0] nbytes,
  input wire logic last,
  output logic idle,
  output logic [7:0] byte_data,
  output logic byte_valid,
  output logic byte_last,
  input wire logic byte_ready
);

  logic [WORD_W-1:0] shift, next_shift;
  logic [2:0] count, next_count;
  logic valid, next_valid;
  logic last_flag, next_last_flag;
  logic blast, next_blast;

  always_comb begin
    next_shift = shift;
    next_count = count;
    next_valid = valid;
    next_last_flag = last_flag;
    next_blast = blast;
    if (valid && byte_ready) begin
      next_shift = {8'h00, shift[WORD_W-1:8]};
      next_count = 3'(count - 3'h1);
      next_blast = last_flag && (count == 3'h2);
      if (count == 3'h1) begin
        next_valid = 1'b0;
      end
    end
    if (!valid && load) begin
      next_shift = word;
      next_count = nbytes;
      next_valid = 1'b1;
      next_last_flag = last;
      next_blast = last && (nbytes == 3'h1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift <= '0;
      count <= 3'h0;
      valid <= 1'b0;
      last_flag <= 1'b0;
      blast <= 1'b0;
    end else if (ce) begin
      shift <= next_shift;
      count <= next_count;
      valid <= next_valid;
      last_flag <= next_last_flag;
      blast <= next_blast;
    end
  end

  assign idle = !valid;
  assign byte_data = shift[7:0];
  assign byte_valid = valid;
  assign byte_last = blast;

  a_lsb_first: assert property (@(posedge clk) disable iff (reset)
    ce && valid && byte_ready && count != 3'h1 |=> byte_data == $past(shift[15:8]))
    else $error("serializer did not move to the next higher byte");

  a_byte_count: assert property (@(posedge clk) disable iff (reset)
    ce && !valid && load && nbytes == 3'h4 && byte_ready |=> valid [*3])
    else $error("four-byte word ended early");

endmodule // nofp_byte_serializer

`default_nettype wire

/* rtl/nofp_field_packer.sv */
/*
  Navigation output field packer: holds receiver and attitude field words
  written over APB, assembles the estimator status word from live flags, and
  streams the selected fields of either group as a byte payload.
  Assumes all flag inputs come from logic on CLK and the byte sink drives
  OUT_READY on CLK.
*/
// Chosen here: the register offsets and the APB register port.
// What this block does
// - NED receiver velocity, three floats, bytes 0-11
// - ECEF receiver velocity, three floats, bytes 0-11
// - Position uncertainty, three NED floats, bytes 0-11
// - Velocity uncertainty, one float, bytes 0-3
// - Time uncertainty, one 32-bit unsigned nanoseconds
// - Attitude mask bits 0-8 select fields in order
// - Attitude fields valid only while estimator tracks
// - Status word 16 bits, bits 13-15 reserved
// - Status bits 1:0 carry orientation quality
// - Bit 2 rate clipped, bit 3 recovering
// - Bits 5:4 nonzero when magnetic interference present
// - Bit 6 set while magnetometer clipped
// - Bits 8:7 nonzero on acceleration interference
// - Bit 9 set while accelerometer clipped
// - Bit 10 internal; host ignores it
// - Bits 11, 12 declared magnetic/acceleration interference
// - Euler field yaw, pitch, roll degrees
// - Quaternion four floats, scalar last
// - Rotation matrix nine floats, column-major
// - Navigation-frame magnetic field, three floats Gauss
// - Navigation-frame acceleration, three floats with gravity
// - Receiver fields refreshed per receiver update
`timescale 1ns/1ps
`default_nettype none

module nofp_field_packer (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic GPS_UPDATE,
  input wire logic ESTIMATOR_TRACKING,
  input wire logic [1:0] ORIENTATION_QUALITY,
  input wire logic RATE_SENSOR_CLIPPED,
  input wire logic RATE_CLIP_RECOVERING,
  input wire logic [1:0] MAGNETIC_INTERFERENCE,
  input wire logic MAGNETOMETER_CLIPPED,
  input wire logic [1:0] ACCEL_INTERFERENCE,
  input wire logic ACCELEROMETER_CLIPPED,
  input wire logic INTERNAL_FLAG,
  input wire logic DECLARED_MAGNETIC_INTERFERENCE,
  input wire logic DECLARED_ACCEL_INTERFERENCE,
  output logic ATT_FIELDS_VALID,
  output logic [7:0] OUT_DATA,
  output logic OUT_VALID,
  output logic OUT_LAST,
  input wire logic OUT_READY
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [31:0] field_mem [0:nofp_pkg::FIELD_WORDS-1];
  nofp_pkg::nofp_state_t state, next_state;
  logic [5:0] ptr, next_ptr;
  logic grp_att, next_grp_att;
  logic gps_pending, next_gps_pending;
  logic att_pending, next_att_pending;
  logic refused, next_refused;
  logic gps_en, next_gps_en;
  logic [15:0] gps_sel, next_gps_sel;
  logic [15:0] att_sel, next_att_sel;
  logic [15:0] status_word, next_status_word;
  logic tracking, next_tracking;
  logic [31:0] prdata, next_prdata;
  logic pready, next_pready;
  logic pslverr, next_pslverr;

  logic setup, access, wr;
  logic field_hit;
  logic [5:0] field_idx;
  logic [nofp_pkg::FIELD_WORDS-1:0] word_sel;
  logic [5:0] last_sel;
  logic att_words_any, gps_any;
  logic ser_load, ser_last, ser_idle;
  logic [31:0] ser_word;
  logic [2:0] ser_nbytes;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && pready;
  assign wr = access && PWRITE;
  assign field_idx = PADDR[7:2];
  assign field_hit = (PADDR[11:8] == nofp_pkg::FIELD_PAGE) && (PADDR[1:0] == 2'h0)
    && (field_idx <= nofp_pkg::ATT_LAST);

  // ----------------------------------------------------------------------
  // Field selection
  // ----------------------------------------------------------------------
  // each word follows its mask bit
  for (genvar i = 0; i < nofp_pkg::FIELD_WORDS; i++) begin : g_sel
    if (i <= 10) begin : g_gps
      assign word_sel[i] = gps_sel[nofp_pkg::nofp_word_field(6'(i))];
    end else begin : g_att
      assign word_sel[i] = att_sel[nofp_pkg::nofp_word_field(6'(i))];
    end
  end

  always_comb begin
    last_sel = nofp_pkg::GPS_FIRST;
    for (int k = 0; k < nofp_pkg::FIELD_WORDS; k++) begin
      if (word_sel[k] && ((k > 10) == grp_att)) begin
        last_sel = 6'(k);
      end
    end
  end

  assign att_words_any = |word_sel[nofp_pkg::FIELD_WORDS-1:11];
  assign gps_any = |word_sel[10:0];

  // ----------------------------------------------------------------------
  // Status word and register file
  // ----------------------------------------------------------------------
  always_comb begin
    next_status_word = 16'h0000;
    next_status_word[nofp_pkg::ST_QUALITY +: 2] = ORIENTATION_QUALITY;
    next_status_word[nofp_pkg::ST_RATE_CLIP] = RATE_SENSOR_CLIPPED;
    next_status_word[nofp_pkg::ST_RATE_REC] = RATE_CLIP_RECOVERING;
    next_status_word[nofp_pkg::ST_MAG_INT +: 2] = MAGNETIC_INTERFERENCE;
    next_status_word[nofp_pkg::ST_MAG_CLIP] = MAGNETOMETER_CLIPPED;
    next_status_word[nofp_pkg::ST_ACC_INT +: 2] = ACCEL_INTERFERENCE;
    next_status_word[nofp_pkg::ST_ACC_CLIP] = ACCELEROMETER_CLIPPED;
    next_status_word[nofp_pkg::ST_INTERNAL] = INTERNAL_FLAG;
    next_status_word[nofp_pkg::ST_DECL_MAG] = DECLARED_MAGNETIC_INTERFERENCE;
    next_status_word[nofp_pkg::ST_DECL_ACC] = DECLARED_ACCEL_INTERFERENCE;
    next_tracking = ESTIMATOR_TRACKING;

    next_gps_en = gps_en;
    next_gps_sel = gps_sel;
    next_att_sel = att_sel;
    next_pready = setup;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (setup) begin
      next_pslverr = 1'b1;
      next_prdata = 32'h0000_0000;
      if (field_hit) begin
        next_pslverr = 1'b0;
        next_prdata = field_mem[field_idx];
      end
      case (PADDR)
        nofp_pkg::OFS_CTRL: begin
          next_pslverr = 1'b0;
          next_prdata[nofp_pkg::CTRL_GPS_EN] = gps_en;
        end
        nofp_pkg::OFS_GPS_SEL: begin
          next_pslverr = 1'b0;
          next_prdata[15:0] = gps_sel;
        end
        nofp_pkg::OFS_ATT_SEL: begin
          next_pslverr = 1'b0;
          next_prdata[15:0] = att_sel;
        end
        nofp_pkg::OFS_STATUS: begin
          next_pslverr = 1'b0;
          next_prdata[nofp_pkg::STAT_BUSY] = (state != nofp_pkg::NOFP_IDLE) || !ser_idle;
          next_prdata[nofp_pkg::STAT_TRACK] = tracking;
          next_prdata[nofp_pkg::STAT_REFUSED] = refused;
          next_prdata[nofp_pkg::STAT_WORD_LO +: 16] = status_word;
        end
        default: begin
        end
      endcase
    end
    if (wr && PADDR == nofp_pkg::OFS_CTRL) begin
      next_gps_en = PWDATA[nofp_pkg::CTRL_GPS_EN];
    end
    if (wr && PADDR == nofp_pkg::OFS_GPS_SEL) begin
      next_gps_sel = PWDATA[15:0] & nofp_pkg::GPS_SEL_USED;
    end
    if (wr && PADDR == nofp_pkg::OFS_ATT_SEL) begin
      next_att_sel = PWDATA[15:0] & nofp_pkg::ATT_SEL_USED;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      status_word <= 16'h0000;
      tracking <= 1'b0;
      gps_en <= 1'b0;
      gps_sel <= nofp_pkg::SEL_RESET;
      att_sel <= nofp_pkg::SEL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (CE) begin
      status_word <= next_status_word;
      tracking <= next_tracking;
      gps_en <= next_gps_en;
      gps_sel <= next_gps_sel;
      att_sel <= next_att_sel;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Field words hold no control state, so they are left out of reset.
  always_ff @(posedge CLK) begin
    if (CE && wr && field_hit) begin
      field_mem[field_idx] <= PWDATA;
    end
  end

  // ----------------------------------------------------------------------
  // Payload sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_ptr = ptr;
    next_grp_att = grp_att;
    next_refused = refused;
    next_att_pending = att_pending;
    next_gps_pending = gps_pending;
    ser_load = 1'b0;
    ser_word = field_mem[ptr];
    ser_nbytes = nofp_pkg::WORD_BYTES;
    ser_last = (ptr == last_sel);
    if (wr && PADDR == nofp_pkg::OFS_STATUS && PWDATA[nofp_pkg::STAT_REFUSED]) begin
      next_refused = 1'b0;
    end
    case (state)
      nofp_pkg::NOFP_IDLE: begin
        if (gps_pending && gps_en) begin
          next_gps_pending = 1'b0;
          if (gps_any) begin
            next_state = nofp_pkg::NOFP_WORDS;
            next_grp_att = 1'b0;
            next_ptr = nofp_pkg::GPS_FIRST;
          end
        end else if (att_pending) begin
          next_att_pending = 1'b0;
          next_grp_att = 1'b1;
          next_ptr = nofp_pkg::ATT_FIRST;
          if (!tracking) begin
            next_refused = 1'b1;
          end else if (att_sel[nofp_pkg::ATT_BIT_STATUS]) begin
            next_state = nofp_pkg::NOFP_STATUS;
          end else if (att_words_any) begin
            next_state = nofp_pkg::NOFP_WORDS;
          end
        end
      end
      nofp_pkg::NOFP_STATUS: begin
        ser_word = {16'h0000, status_word};
        ser_nbytes = nofp_pkg::STATUS_BYTES;
        ser_last = !att_words_any;
        // status word leads as two bytes
        if (ser_idle) begin
          ser_load = 1'b1;
          next_state = att_words_any ? nofp_pkg::NOFP_WORDS : nofp_pkg::NOFP_IDLE;
        end
      end
      nofp_pkg::NOFP_WORDS: begin
        // words go out in ascending order
        if (!word_sel[ptr] || ser_idle) begin
          ser_load = word_sel[ptr];
          if (ptr == last_sel || ptr == nofp_pkg::ATT_LAST
              || (!grp_att && ptr == nofp_pkg::GPS_LAST)) begin
            next_state = nofp_pkg::NOFP_IDLE;
          end else begin
            next_ptr = 6'(ptr + 6'h01);
          end
        end
      end
      default: begin
        next_state = nofp_pkg::NOFP_IDLE;
      end
    endcase
    // a receiver update always leaves a request
    if (GPS_UPDATE) begin
      next_gps_pending = 1'b1;
    end
    if (wr && PADDR == nofp_pkg::OFS_CTRL && PWDATA[nofp_pkg::CTRL_ATT_SEND]) begin
      next_att_pending = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= nofp_pkg::NOFP_IDLE;
      ptr <= nofp_pkg::GPS_FIRST;
      grp_att <= 1'b0;
      refused <= 1'b0;
      att_pending <= 1'b0;
      gps_pending <= 1'b0;
    end else if (CE) begin
      state <= next_state;
      ptr <= next_ptr;
      grp_att <= next_grp_att;
      refused <= next_refused;
      att_pending <= next_att_pending;
      gps_pending <= next_gps_pending;
    end
  end

  nofp_byte_serializer #(
    .WORD_W(32)
  ) u_ser (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .load(ser_load),
    .word(ser_word),
    .nbytes(ser_nbytes),
    .last(ser_last),
    .idle(ser_idle),
    .byte_data(OUT_DATA),
    .byte_valid(OUT_VALID),
    .byte_last(OUT_LAST),
    .byte_ready(OUT_READY)
  );

  assign PRDATA = prdata;
  assign PREADY = pready;
  assign PSLVERR = pslverr;
  assign ATT_FIELDS_VALID = tracking;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_reserved_status: assert property (@(posedge CLK) disable iff (RESET)
    status_word[15:13] == 3'h0)
    else $error("reserved status bits set");

  a_quality_rate: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> status_word[3:0] == {$past(RATE_CLIP_RECOVERING), $past(RATE_SENSOR_CLIPPED),
      $past(ORIENTATION_QUALITY)})
    else $error("quality or rate bits wrong");

  a_mag_bits: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> status_word[6:4] == {$past(MAGNETOMETER_CLIPPED), $past(MAGNETIC_INTERFERENCE)})
    else $error("magnetic bits wrong");

  a_accel_bits: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> status_word[12:7] == {$past(DECLARED_ACCEL_INTERFERENCE),
      $past(DECLARED_MAGNETIC_INTERFERENCE), $past(INTERNAL_FLAG),
      $past(ACCELEROMETER_CLIPPED), $past(ACCEL_INTERFERENCE)})
    else $error("acceleration bits wrong");

  a_mask_reserved: assert property (@(posedge CLK) disable iff (RESET)
    att_sel[15:9] == 7'h00)
    else $error("reserved mask bits kept");

  a_att_tracking: assert property (@(posedge CLK) disable iff (RESET)
    CE && state == nofp_pkg::NOFP_IDLE && att_pending && !(gps_pending && gps_en) && !tracking
    |=> refused && state == nofp_pkg::NOFP_IDLE)
    else $error("attitude payload started without tracking");

  a_gps_refresh: assert property (@(posedge CLK) disable iff (RESET)
    CE && GPS_UPDATE |=> gps_pending)
    else $error("receiver update lost");

  a_load_select: assert property (@(posedge CLK) disable iff (RESET)
    ser_load && state == nofp_pkg::NOFP_WORDS |-> word_sel[ptr] && ser_nbytes == 3'h4)
    else $error("unselected or short field word loaded");

  a_apb_answer: assert property (@(posedge CLK) disable iff (RESET)
    CE && PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("bus answer not one cycle after setup");

endmodule // nofp_field_packer

`default_nettype wire

/* verification/nofp_host_sink.sv */
/*
  Host-side byte sink for the payload stream: takes bytes at once, or with
  random stalls so that held bytes are seen across waits.
  Assumes the packer holds its byte and valid until they are accepted.
*/
`timescale 1ns/1ps
`default_nettype none

module nofp_host_sink (
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  output var logic byte_ready
);
  int seed = 77711;

  // Stalls are random rather than periodic, so no fixed cadence can hide a slip.
  always @(posedge clk or posedge reset) begin
    if (reset)
      byte_ready <= 1'h0;
    else
      byte_ready <= slow ? 1'($random(seed)) : 1'h1;
  end
endmodule // nofp_host_sink

`default_nettype wire

/* verification/testbench.sv */
/*
  Self-checking bench for the field packer: APB tasks, random field words
  and status flags, payload capture and comparison against expectations.
  Assumes the host sink model is compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk, reset, ce, psel, penable, pwrite, gps_update, tracking, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, att_valid, out_valid, out_last, out_ready;
  logic [7:0] out_data;
  logic [1:0] quality, mag_int, acc_int;
  logic rclip, rrec, mclip, aclip, internal, dmag, dacc;
  logic [15:0] sel;
  logic [31:0] fw [42];
  logic [7:0] rx[$];
  logic [7:0] exq[$];
  int failures, checks, cycles, last_at, seed;

  nofp_field_packer u_dut (.CLK(clk), .RESET(reset), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .GPS_UPDATE(gps_update),
    .ESTIMATOR_TRACKING(tracking), .ORIENTATION_QUALITY(quality),
    .RATE_SENSOR_CLIPPED(rclip), .RATE_CLIP_RECOVERING(rrec),
    .MAGNETIC_INTERFERENCE(mag_int), .MAGNETOMETER_CLIPPED(mclip),
    .ACCEL_INTERFERENCE(acc_int), .ACCELEROMETER_CLIPPED(aclip),
    .INTERNAL_FLAG(internal), .DECLARED_MAGNETIC_INTERFERENCE(dmag),
    .DECLARED_ACCEL_INTERFERENCE(dacc), .ATT_FIELDS_VALID(att_valid),
    .OUT_DATA(out_data), .OUT_VALID(out_valid), .OUT_LAST(out_last),
    .OUT_READY(out_ready));

  nofp_host_sink u_sink (.clk(clk), .reset(reset), .slow(slow), .byte_ready(out_ready));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // --------------------------------------------------------------------
  // Capture, timeout and reporting
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (ce && out_valid === 1'h1 && out_ready) begin
      if (out_last === 1'h1)
        last_at = rx.size();
      rx.push_back(out_data);
    end
    if (cycles > 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // --------------------------------------------------------------------
  // Bus cycles and stimulus
  // --------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50)
      failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic pulse;
    @(posedge clk);
    gps_update <= 1'h1;
    @(posedge clk);
    gps_update <= 1'h0;
  endtask

  function automatic logic [15:0] st_exp;
    return {3'h0, dacc, dmag, internal, aclip, acc_int, mclip, mag_int, rrec, rclip, quality};
  endfunction

  function automatic int owner(input int i);
    int e[13] = '{3, 6, 9, 10, 11, 14, 18, 27, 30, 33, 36, 39, 42};
    int b[13] = '{7, 8, 9, 10, 11, 1, 2, 3, 4, 5, 6, 7, 8};
    for (int k = 0; k < 13; k++)
      if (i < e[k])
        return b[k];
    return 0;
  endfunction

  // Status word first, then each selected word, least significant byte first.
  task automatic build(input bit att);
    logic [15:0] st;
    st = st_exp();
    exq.delete();
    if (att && sel[0]) begin
      exq.push_back(st[7:0]);
      exq.push_back(st[15:8]);
    end
    for (int i = (att ? 11 : 0); i < (att ? 42 : 11); i++)
      if (sel[owner(i)])
        for (int b = 0; b < 4; b++)
          exq.push_back(fw[i][8*b +: 8]);
  endtask

  task automatic wait_cmp(input string name);
    int n;
    n = 0;
    while (rx.size() < exq.size() && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (10) @(posedge clk);
    check({name, " size"}, rx.size(), exq.size());
    if (exq.size() > 0)
      check({name, " last"}, last_at, exq.size() - 1);
    for (int i = 0; i < exq.size() && i < rx.size(); i++)
      check(name, rx[i], exq[i]);
    rx.delete();
    last_at = -1;
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    seed = 77711;
    {reset, ce} = 2'h3;
    {psel, penable, pwrite, gps_update, tracking, slow} = 6'h0;
    {paddr, pwdata} = 44'h0;
    {quality, mag_int, acc_int, rclip, rrec, mclip, aclip, internal, dmag, dacc} = 13'h0;
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    apb(1'h0, nofp_pkg::OFS_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'h0, nofp_pkg::OFS_ATT_SEL, 32'h0);
    check("att_sel reset", rd, 32'h0);
    apb(1'h0, 12'h0FC, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    for (int i = 0; i < 42; i++) begin
      fw[i] = $random(seed);
      apb(1'h1, {nofp_pkg::FIELD_PAGE, 8'h00} + 12'(4 * i), fw[i]);
    end
    apb(1'h0, {nofp_pkg::FIELD_PAGE, 8'h14}, 32'h0);
    check("field word 5", rd, fw[5]);
    // A receiver update waits while the group is disabled.
    sel = 16'h0F80;
    apb(1'h1, nofp_pkg::OFS_GPS_SEL, 32'(sel));
    pulse();
    exq.delete();
    wait_cmp("gps held");
    build(1'h0);
    apb(1'h1, nofp_pkg::OFS_CTRL, 32'h1);
    wait_cmp("gps");
    for (int k = 0; k < 6; k++) begin
      slow <= k[0];
      sel = (16'($random(seed)) & 16'h0F80) | 16'h0800;
      apb(1'h1, nofp_pkg::OFS_GPS_SEL, 32'(sel));
      pulse();
      // A low clock enable must hold the pending request without sending bytes.
      if (k == 2) begin
        ce <= 1'h0;
        repeat (20) @(posedge clk);
        check("frozen", rx.size(), 32'h0);
        ce <= 1'h1;
      end
      build(1'h0);
      wait_cmp("gps rand");
    end
    tracking <= 1'h1;
    for (int k = 0; k < 8; k++) begin
      {quality, mag_int, acc_int, rclip, rrec, mclip, aclip, internal, dmag, dacc} <= 13'($random(seed));
      sel = (k == 0) ? 16'h01FF : (k == 1) ? 16'h0100 : 16'($random(seed)) & 16'h01FF;
      // reserved mask bits written as zero
      apb(1'h1, nofp_pkg::OFS_ATT_SEL, 32'(sel));
      apb(1'h0, nofp_pkg::OFS_STATUS, 32'h0);
      check("status word", rd[31:16], st_exp());
      check("tracking valid", 32'(att_valid), 32'h1);
      build(1'h1);
      apb(1'h1, nofp_pkg::OFS_CTRL, 32'h3);
      wait_cmp("attitude");
    end
    apb(1'h1, nofp_pkg::OFS_ATT_SEL, 32'h0000FFFF);
    apb(1'h0, nofp_pkg::OFS_ATT_SEL, 32'h0);
    check("att_sel used", rd, 32'h000001FF);
    tracking <= 1'h0;
    repeat (2) @(posedge clk);
    check("not tracking", 32'(att_valid), 32'h0);
    apb(1'h1, nofp_pkg::OFS_CTRL, 32'h3);
    exq.delete();
    wait_cmp("refused");
    apb(1'h0, nofp_pkg::OFS_STATUS, 32'h0);
    check("refused flag", 32'(rd[2]), 32'h1);
    end_sim();
  end
endmodule // testbench

`default_nettype wire
